//--- dv/dram_row_model.sv
// Purpose: One-word DRAM row seen from the controller data pins
// Assumes: Check bits follow write data by one cycle
// Notes: Undriven lanes show the inverse of the last value
`timescale 1ns/100ps
module dram_row_model (
    input wire logic core_clk_i,
    input wire logic store_i,
    input wire logic narrow_i,
    input wire logic rd_valid_i,
    input wire logic [63:0] wr_data_i,
    input wire logic [7:0] wr_check_i,
    output logic [63:0] rd_data_o,
    output logic [7:0] rd_check_o
);
    logic [63:0] mem_ff;
    logic [7:0] chk_ff;
    logic st_ff;
    always_ff @(posedge core_clk_i) begin
        st_ff <= store_i;
        if (store_i) mem_ff <= wr_data_i;
        if (st_ff) chk_ff <= wr_check_i;
    end
    assign rd_data_o = rd_valid_i ? mem_ff : ~mem_ff;
    // A 64-bit row has no check lanes, so they float
    assign rd_check_o = (rd_valid_i && !narrow_i) ? chk_ff : ~chk_ff;
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the row address mux and parity
// Assumes: Row 0 covers low memory with reset boundaries
// Notes: AXI flags sampled at the falling edge to avoid races
`timescale 1ns/100ps
module testbench;
    import dram_addr_pkg::*;
    logic core_clk_i = 0, reset_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, host_req_i = 0, host_write_i = 0, col_phase_i = 0, write_cas_before_ras_cycle_i = 0, rd_valid_i = 0;
    logic store = 0, narrow = 0, fr_seen = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mem_hit_o, pci_hit_o, edo_detect_o, bedo_prog_o, fast_refresh_o, serr_o;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, wr_check_o, timing_o, rd_check_i;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, row_type_o, r;
    logic [31:3] host_addr_bus_i = 0;
    logic [63:0] wr_data_i = 0, rd_data_i;
    logic [11:0] mem_addr_bus_o;
    logic [2:0] row_sel_o;
    int num_errors = 0, tests_run = 0;
    localparam logic [31:0] TA[11] = '{32'h0100_0000, 32'h0080_0000, 32'h0040_0000, 32'h0020_0000, 32'h0000_1000,
        32'h0400_0000, 32'h0100_0000, 32'h0040_0000, 32'h0000_0800, 32'h0000_0008, 32'h0200_0000};
    localparam logic [10:0] TC = 11'h7E0;
    localparam logic [11:0] TE[11] = '{12'h800, 12'h400, 12'h000, 12'h200, 12'h001, 12'h800, 12'h400, 12'h200,
        12'h100, 12'h001, 12'h000};
    dram_row_addr dut_u (.*);
    dram_row_model model_u (.core_clk_i(core_clk_i), .store_i(store), .narrow_i(narrow), .rd_valid_i(rd_valid_i),
        .wr_data_i(wr_data_i), .wr_check_i(wr_check_o), .rd_data_o(rd_data_i), .rd_check_o(rd_check_i));
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) if (fast_refresh_o) fr_seen <= 1'b1;
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task timeout;
        num_errors++;
        finish_test();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge core_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge core_clk_i);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (b !== 1'b1) timeout();
        chk(r, RESP_OKAY);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
        logic ar, v;
        @(posedge core_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge core_clk_i);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk_i);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) break;
        end
        s_axi_rready <= 1'b0;
        if (v !== 1'b1) timeout();
        chk(d, e);
        chk(r, re);
    endtask
    task automatic host(input logic [31:0] a, input logic c, input logic w);
        @(posedge core_clk_i);
        host_addr_bus_i <= a[31:3];
        col_phase_i <= c;
        write_cas_before_ras_cycle_i <= w;
        host_req_i <= 1'b1;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    task pulse;
        @(posedge core_clk_i);
        rd_valid_i <= 1'b1;
        @(posedge core_clk_i);
        rd_valid_i <= 1'b0;
    endtask
    initial begin
        #2_000_000;
        timeout();
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        axi_rd(CTRL_OFS, CTRL_RST, RESP_OKAY);
        axi_rd(ERR_CMD_OFS, ERR_CMD_RST, RESP_OKAY);
        axi_rd(BOUND_LO_OFS, BOUND_RST, RESP_OKAY);
        axi_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        $display("reset test done");
        axi_wr(GEOM_OFS, 32'h0000_0000);
        for (int i = 0; i < 11; i++) begin
            host(TA[i], TC[i], 1'b0);
            chk(mem_addr_bus_o, TE[i]);
            chk(mem_hit_o, 1'b1);
        end
        // Every geometry code, column phase with only A25 then only A24
        for (int g = 0; g < 6; g++) begin
            axi_wr(GEOM_OFS, 32'(g));
            host(32'h0200_0000, 1'b1, 1'b0);
            chk(mem_addr_bus_o, (g > 3) ? 12'h400 : 12'h000);
            host(32'h0100_0000, 1'b1, 1'b0);
            chk(mem_addr_bus_o, (g > 3) ? 12'h000 : 12'h400);
        end
        host(32'h0800_0000, 1'b0, 1'b0);
        chk({pci_hit_o, mem_hit_o}, 2'h2);
        host(32'h0002_1000, 1'b0, 1'b1);
        chk(bedo_prog_o, 1'b1);
        host(32'h0002_2000, 1'b0, 1'b1);
        chk(bedo_prog_o, 1'b0);
        axi_wr(REFRESH_OFS, 32'h0000_0100);
        repeat (3) @(posedge core_clk_i);
        chk(fr_seen, 1'b1);
        axi_wr(CTRL_OFS, 32'h0000_0002);
        chk(edo_detect_o, 1'b1);
        axi_wr(ROW_TYPE_OFS, 32'h0000_0002);
        axi_wr(TIMING_OFS, 32'h0000_005A);
        host(32'h0000_0000, 1'b0, 1'b0);
        chk({row_type_o, timing_o}, 10'h25A);
        $display("address and control test done");
        // Parity off: no check bits and no error even on a 64-bit row
        @(posedge core_clk_i);
        wr_data_i <= 64'h0001_0300_FF07_8000;
        narrow <= 1'b1;
        pulse();
        @(negedge core_clk_i);
        chk(wr_check_o, 8'h00);
        axi_rd(ERR_STS_OFS, 32'h0000_0000, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h0000_0001);
        @(negedge core_clk_i);
        chk(wr_check_o, 8'h46);
        @(posedge core_clk_i);
        store <= 1'b1;
        narrow <= 1'b0;
        @(posedge core_clk_i);
        store <= 1'b0;
        pulse();
        axi_rd(ERR_STS_OFS, 32'h0000_0000, RESP_OKAY);
        narrow <= 1'b1;
        pulse();
        axi_rd(ERR_STS_OFS, 32'h0000_0010, RESP_OKAY);
        chk(serr_o, 1'b0);
        axi_wr(ERR_CMD_OFS, 32'h0000_0002);
        chk(serr_o, 1'b1);
        axi_wr(ERR_STS_OFS, 32'h0000_0010);
        axi_rd(ERR_STS_OFS, 32'h0000_0000, RESP_OKAY);
        $display("parity test done");
        // Cumulative boundaries 32 MB and 64 MB, gap over the second 8 MB
        axi_wr(BOUND_LO_OFS, 32'h1010_0804);
        axi_wr(GAP_OFS, 32'h0000_0201);
        host(32'h0200_0000, 1'b0, 1'b0);
        chk({row_sel_o, mem_hit_o}, 4'h3);
        host(32'h0080_0000, 1'b0, 1'b0);
        chk({pci_hit_o, mem_hit_o}, 2'h2);
        axi_rd(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
        // Mid-run reset must drop parity, SERR enable and boundaries back
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(negedge core_clk_i);
        chk({serr_o, wr_check_o, s_axi_bvalid, s_axi_rvalid}, 11'h000);
        axi_rd(CTRL_OFS, CTRL_RST, RESP_OKAY);
        axi_rd(ERR_CMD_OFS, ERR_CMD_RST, RESP_OKAY);
        axi_rd(BOUND_LO_OFS, BOUND_RST, RESP_OKAY);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule

//--- include/dram_addr_pkg.sv
// Purpose: Shared constants for the DRAM row addressing and parity block
// Assumes: 25 MHz core clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit registers
package dram_addr_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ROW_TYPE_OFS = 8'h04;
    localparam logic [7:0] GEOM_OFS = 8'h08;
    localparam logic [7:0] TIMING_OFS = 8'h0C;
    localparam logic [7:0] ERR_CMD_OFS = 8'h10;
    localparam logic [7:0] ERR_STS_OFS = 8'h14;
    localparam logic [7:0] BOUND_LO_OFS = 8'h18;
    localparam logic [7:0] BOUND_HI_OFS = 8'h1C;
    localparam logic [7:0] REFRESH_OFS = 8'h20;
    localparam logic [7:0] GAP_OFS = 8'h24;
    localparam logic [7:0] STATUS_OFS = 8'h28;
    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_PAR_EN_BIT = 0;
    localparam int CTRL_EDO_DET_BIT = 1;
    localparam int ERR_CMD_SERR_PAR_BIT = 1;
    localparam int ERR_STS_PAR_BIT = 4;
    localparam int REFRESH_FAST_BIT = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ERR_CMD_RST = 32'h0000_0000;
    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic [31:0] BOUND_RST = 32'h1010_1010;
    localparam logic [31:0] GAP_RST = 32'h0000_0000;
    localparam logic [31:0] REFRESH_RST = 32'h0000_0000;
    // Row base offset that marks a BEDO burst-order program cycle
    localparam logic [26:0] BEDO_PROG_OFS = 27'h002_1000;
    // Boundary registers count in 8 MB units: host bit 23 and up
    localparam int BOUND_SHIFT = 23;
    localparam int AXI_OKAY = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Geometry code per row: rows x columns
    typedef enum logic [2:0] {
        GEOM_10X10,
        GEOM_11X10,
        GEOM_11X11,
        GEOM_12X10,
        GEOM_12X11,
        GEOM_12X12
    } geom_e;
    typedef enum logic [1:0] {
        TYPE_FPM,
        TYPE_EDO,
        TYPE_BEDO
    } dram_type_e;
endpackage

//--- verilog/byte_parity.sv
// Purpose: Even parity per 8-bit byte of a data word
// Assumes: Width is a whole number of bytes
// Notes: Pure combinational; used for generation and checking
`timescale 1ns/100ps
module byte_parity #(
    parameter int BYTES = 8
) (
    input wire logic [BYTES*8-1:0] data_i,
    output logic [BYTES-1:0] par_o
);
    initial begin
        if (BYTES < 1) begin
            $error("byte_parity needs at least one byte");
        end
    end
    // ----------------------------------------------------------------
    // Per-byte reduction
    // ----------------------------------------------------------------
    for (genvar g = 0; g < BYTES; g++) begin : gen_byte
        // Check bit makes each 9-bit group carry an even count of ones
        assign par_o[g] = ^data_i[g*8 +: 8];
    end
endmodule

//--- verilog/dram_row_addr.sv
// Purpose: Host-to-DRAM address mux, row decode and byte parity check
// Assumes: One core clock; access strobes come from the same domain
// Notes: Refresh and timing engines sit outside and read the outputs
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module dram_row_addr
#(
    parameter int ROWS = 8
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Host access request
    input wire logic [31:3] host_addr_bus_i,
    input wire logic host_req_i,
    input wire logic host_write_i,
    input wire logic col_phase_i,
    input wire logic write_cas_before_ras_cycle_i,
    // DRAM data path
    input wire logic [63:0] wr_data_i,
    output logic [7:0] wr_check_o,
    input wire logic [63:0] rd_data_i,
    input wire logic [7:0] rd_check_i,
    input wire logic rd_valid_i,
    // Decoded access
    output logic [11:0] mem_addr_bus_o,
    output logic mem_hit_o,
    output logic pci_hit_o,
    output logic [2:0] row_sel_o,
    output logic [1:0] row_type_o,
    output logic [7:0] timing_o,
    output logic edo_detect_o,
    output logic bedo_prog_o,
    output logic fast_refresh_o,
    output logic serr_o
);
    import dram_addr_pkg::*;

    initial begin
        if (ROWS != 8) begin
            $error("dram_row_addr serves exactly eight rows");
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [15:0] row_type_ff;
    logic [23:0] geom_ff;
    logic [7:0] timing_ff;
    logic [7:0] error_command_reg_ff;
    logic error_status_reg_ff;
    logic [63:0] row_boundary_reg_ff;
    logic [31:0] refresh_rate_reg_ff;
    logic [15:0] gap_ff;
    logic fast_refresh_ff;

    logic aw_hold_ff;
    logic w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] bresp_ff;
    logic [1:0] rresp_ff;

    function automatic logic known_ofs(input logic [7:0] a);
        known_ofs = (a[1:0] == 2'h0) && (a <= STATUS_OFS);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_word;
    logic [3:0] wr_strb;
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_word = w_hold_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
    assign do_write = (aw_hold_ff || (s_axi_awvalid && s_axi_awready))
                      && (w_hold_ff || (s_axi_wvalid && s_axi_wready));
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= known_ofs(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_hold_ff <= 1'b1;
                    awaddr_ff <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_hold_ff <= 1'b1;
                    wdata_ff <= s_axi_wdata;
                    wstrb_ff <= s_axi_wstrb;
                end
                if (bvalid_ff && s_axi_bready) begin
                    bvalid_ff <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic fast_req;
    assign fast_req = do_write && (wr_addr == REFRESH_OFS) && wr_strb[1] && wr_word[REFRESH_FAST_BIT];

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_ff <= CTRL_RST;
            row_type_ff <= 16'h0000;
            geom_ff <= 24'h00_0000;
            timing_ff <= TIMING_RST[7:0];
            error_command_reg_ff <= ERR_CMD_RST[7:0];
            row_boundary_reg_ff <= {BOUND_RST, BOUND_RST};
            refresh_rate_reg_ff <= REFRESH_RST;
            gap_ff <= GAP_RST[15:0];
        end else if (do_write) begin
            unique case (wr_addr)
                CTRL_OFS: ctrl_ff <= merge(ctrl_ff, wr_word, wr_strb);
                ROW_TYPE_OFS: row_type_ff <= 16'(merge({16'h0000, row_type_ff}, wr_word, wr_strb));
                GEOM_OFS: geom_ff <= 24'(merge({8'h00, geom_ff}, wr_word, wr_strb));
                TIMING_OFS: timing_ff <= 8'(merge({24'h0, timing_ff}, wr_word, wr_strb));
                ERR_CMD_OFS: error_command_reg_ff <= 8'(merge({24'h0, error_command_reg_ff}, wr_word, wr_strb));
                BOUND_LO_OFS: row_boundary_reg_ff[31:0] <= merge(row_boundary_reg_ff[31:0], wr_word, wr_strb);
                BOUND_HI_OFS: row_boundary_reg_ff[63:32] <= merge(row_boundary_reg_ff[63:32], wr_word, wr_strb);
                REFRESH_OFS: refresh_rate_reg_ff <= merge(refresh_rate_reg_ff, wr_word, wr_strb);
                GAP_OFS: gap_ff <= 16'(merge({16'h0, gap_ff}, wr_word, wr_strb));
                default: ;
            endcase
        end
    end

    // Fast refresh request is a one-cycle pulse to the refresh engine
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fast_refresh_ff <= 1'b0;
        end else begin
            fast_refresh_ff <= fast_req;
        end
    end
    assign fast_refresh_o = fast_refresh_ff;

    // ----------------------------------------------------------------
    // Row decode and gap
    // ----------------------------------------------------------------
    // Boundaries count 8 MB units; the first row whose top lies above wins
    logic [2:0] row_hit;
    logic in_mem;
    logic in_gap;
    logic [8:0] addr_units;
    assign addr_units = host_addr_bus_i[31:BOUND_SHIFT];
    always_comb begin
        row_hit = 3'h0;
        in_mem = 1'b0;
        for (int r = ROWS - 1; r >= 0; r--) begin
            if (addr_units < {1'b0, row_boundary_reg_ff[r*8 +: 8]}) begin
                row_hit = 3'(r);
                in_mem = 1'b1;
            end
        end
    end
    // Gap: start and end in 8 MB units, empty when end is not above start
    assign in_gap = (addr_units >= {1'b0, gap_ff[7:0]}) && (addr_units < {1'b0, gap_ff[15:8]});

    // ----------------------------------------------------------------
    // Address multiplexer
    // ----------------------------------------------------------------
    geom_e cur_geom;
    logic wide_col;
    assign cur_geom = geom_e'(geom_ff[row_hit*3 +: 3]);
    assign wide_col = (cur_geom == GEOM_12X11) || (cur_geom == GEOM_12X12);

    logic [11:0] nxt_mem_addr;
    logic [11:0] mem_addr_ff;
    always_comb begin
        if (col_phase_i) begin
            // Page offset on the low nine bits spans 4 KB over 64-bit rows
            nxt_mem_addr = {host_addr_bus_i[26], wide_col ? host_addr_bus_i[25] : host_addr_bus_i[24],
                            host_addr_bus_i[22], host_addr_bus_i[11:3]};
        end else begin
            nxt_mem_addr = {host_addr_bus_i[24], host_addr_bus_i[23], host_addr_bus_i[21:12]};
        end
    end

    logic mem_hit_ff;
    logic pci_hit_ff;
    logic [2:0] row_sel_ff;
    logic bedo_prog_ff;
    logic [26:0] row_base;
    assign row_base = (row_hit == 3'h0) ? 27'h0 :
                      27'({row_boundary_reg_ff[(row_hit-3'h1)*8 +: 8], 23'h0});
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_addr_ff <= 12'h000;
            mem_hit_ff <= 1'b0;
            pci_hit_ff <= 1'b0;
            row_sel_ff <= 3'h0;
            bedo_prog_ff <= 1'b0;
        end else begin
            mem_addr_ff <= nxt_mem_addr;
            mem_hit_ff <= host_req_i && in_mem && !in_gap;
            pci_hit_ff <= host_req_i && !(in_mem && !in_gap);
            row_sel_ff <= row_hit;
            // A WRITE_CAS_BEFORE_RAS_CYCLE at base plus the program offset selects x86 burst order
            bedo_prog_ff <= write_cas_before_ras_cycle_i && in_mem &&
                            (host_addr_bus_i[26:3] == 24'((row_base + BEDO_PROG_OFS) >> 3));
        end
    end
    assign mem_addr_bus_o = mem_addr_ff;
    assign mem_hit_o = mem_hit_ff;
    assign pci_hit_o = pci_hit_ff;
    assign row_sel_o = row_sel_ff;
    assign bedo_prog_o = bedo_prog_ff;
    // Per-row type rides with global timing to the timing engine
    assign row_type_o = row_type_ff[row_sel_ff*2 +: 2];
    assign timing_o = timing_ff;
    assign edo_detect_o = ctrl_ff[CTRL_EDO_DET_BIT];

    // ----------------------------------------------------------------
    // Parity generate and check
    // ----------------------------------------------------------------
    logic [7:0] gen_par;
    logic [7:0] rd_par;
    byte_parity #(.BYTES(8)) u_wr_par (
        .data_i(wr_data_i),
        .par_o(gen_par)
    );
    byte_parity #(.BYTES(8)) u_rd_par (
        .data_i(rd_data_i),
        .par_o(rd_par)
    );
    logic par_en;
    logic par_err;
    assign par_en = ctrl_ff[CTRL_PAR_EN_BIT];
    // Check bits hold zero while disabled, so writes are harmless then
    logic [7:0] wr_check_ff;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_check_ff <= 8'h00;
        end else begin
            wr_check_ff <= par_en ? gen_par : 8'h00;
        end
    end
    assign wr_check_o = wr_check_ff;
    // Missing check bits on a 64-bit row read back as a mismatch
    assign par_err = par_en && rd_valid_i && (rd_par != rd_check_i);

    // Status clears by writing one to bit 4; a new error wins over the clear
    logic sts_clr;
    assign sts_clr = do_write && (wr_addr == ERR_STS_OFS) && wr_strb[0] && wr_word[ERR_STS_PAR_BIT];
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            error_status_reg_ff <= 1'b0;
        end else if (par_err) begin
            error_status_reg_ff <= 1'b1;
        end else if (sts_clr) begin
            error_status_reg_ff <= 1'b0;
        end
    end
    assign serr_o = error_status_reg_ff && error_command_reg_ff[ERR_CMD_SERR_PAR_BIT];

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            CTRL_OFS: rd_mux = ctrl_ff;
            ROW_TYPE_OFS: rd_mux = {16'h0000, row_type_ff};
            GEOM_OFS: rd_mux = {8'h00, geom_ff};
            TIMING_OFS: rd_mux = {24'h00_0000, timing_ff};
            ERR_CMD_OFS: rd_mux = {24'h00_0000, error_command_reg_ff};
            ERR_STS_OFS: rd_mux = {27'h0, error_status_reg_ff, 4'h0};
            BOUND_LO_OFS: rd_mux = row_boundary_reg_ff[31:0];
            BOUND_HI_OFS: rd_mux = row_boundary_reg_ff[63:32];
            REFRESH_OFS: rd_mux = refresh_rate_reg_ff;
            GAP_OFS: rd_mux = {16'h0000, gap_ff};
            STATUS_OFS: rd_mux = {27'h0, row_sel_ff, mem_hit_ff, pci_hit_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= known_ofs(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    row_addr_map_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !col_phase_i |=> mem_addr_bus_o == {$past(host_addr_bus_i[24]), $past(host_addr_bus_i[23]),
                                            $past(host_addr_bus_i[21:12])})
        else $error("row phase address wrong");
    col_addr_map_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        col_phase_i |=> mem_addr_bus_o[11] == $past(host_addr_bus_i[26])
                     && mem_addr_bus_o[9:0] == {$past(host_addr_bus_i[22]), $past(host_addr_bus_i[11:3])})
        else $error("column phase address wrong");
    col_a25_swap_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        col_phase_i && wide_col |=> mem_addr_bus_o[10] == $past(host_addr_bus_i[25]))
        else $error("A25 not substituted");
    par_reset_off_a: assert property (@(posedge core_clk_i)
        $fell(reset_i) |-> !par_en && !error_command_reg_ff[ERR_CMD_SERR_PAR_BIT])
        else $error("checking not off after reset");
    par_error_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        par_err |=> error_status_reg_ff)
        else $error("parity error not logged");
    serr_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !error_command_reg_ff[ERR_CMD_SERR_PAR_BIT] |-> !serr_o)
        else $error("SERR while disabled");
    par_only_enabled_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !par_en |=> !$rose(error_status_reg_ff))
        else $error("error flagged while parity off");
    wr_check_gen_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        par_en |=> wr_check_o == $past(gen_par))
        else $error("write check bits wrong");
    fast_refresh_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fast_req |=> fast_refresh_o ##1 !fast_refresh_o)
        else $error("fast refresh pulse missing");
    edo_detect_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        do_write && (wr_addr == CTRL_OFS) && wr_strb[0] |=> edo_detect_o == $past(wr_word[CTRL_EDO_DET_BIT]))
        else $error("EDO detect mode mismatch");

    write_cas_before_ras_cycle_prog_c: cover property (@(posedge core_clk_i) disable iff (reset_i) bedo_prog_o ##[1:20] fast_refresh_o);
    par_error_c: cover property (@(posedge core_clk_i) disable iff (reset_i) par_err ##1 serr_o);
    wide_col_c: cover property (@(posedge core_clk_i) disable iff (reset_i) col_phase_i && wide_col);
endmodule
